// ### shared/sar_seq_pkg.sv
// package: constants and types for the serial-frame conversion sequencer
// Notes on behaviour
// - for the first three serial clock cycles after the frame opens the sample switch tracks the input.
// - from the fourth through the sixteenth cycle the sample is held and converted.
// - the input is captured at the fourth falling serial clock edge of each conversion.
// - a frame is the whole time the active-low frame select stays low, bounded by its edges.
// - within one frame, conversions start sixteen serial clock periods apart; a new frame restarts at the first cycle at once.
// - each sixteen-cycle group does one conversion and shifts its result out.
// - while tracking, the sample switch connects to one of four inputs picked by the stored address.
// - while holding, trial codes step through the internal DAC, one bit per rising edge, for all eight bits.
// - the result leaves most significant bit first, its first bit on the fifth serial clock.
// - the command input is sampled on the first eight rising edges of each conversion.
// - command bits 4 and 3 pick the channel, 00 giving input one; all other bits are ignored.
// - the result output is released whenever frame select is high and driven only while low.
package sar_seq_pkg;
  localparam int          RESULT_BITS   = 8;
  localparam int          CMD_BITS      = 8;
  localparam int          GROUP_CYCLES  = 16;
  localparam int          TRACK_CYCLES  = 3;
  localparam logic [4:0]  HOLD_EDGE     = 5'h04;
  localparam logic [4:0]  FIRST_OUT_CLK = 5'h05;
  localparam logic [4:0]  LAST_CMD_RISE = 5'h08;
  localparam logic [4:0]  GROUP_END     = 5'h10;
  localparam int          CHAN_HI_POS   = 4;
  localparam int          CHAN_LO_POS   = 3;
  localparam logic [1:0]  CHAN_RESET    = 2'h0;
  typedef enum logic [1:0] {IDLE, TRACK, HOLD} phase_type;
endpackage

// ### src/sar_adc_serial_frame_sequencer.sv
// module: serial-frame sequencer for a four-input successive-approximation converter
`timescale 1ns/10ps
`default_nettype none
module sar_adc_serial_frame_sequencer (
  // system
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // serial pins
  input  wire logic        frameSelectN,
  input  wire logic        serialClk,
  input  wire logic        cmdIn,
  output logic             resultOut,
  output logic             resultOutEn,
  // analog front end
  input  wire logic        comparatorHigh,
  output logic [3:0]       sampleSwitch,
  output logic             comparatorBalanceSwitch,
  output logic [7:0]       dacCode,
  // converted words to the system
  output logic [7:0]       resultData,
  output logic [1:0]       resultChannel,
  output logic             resultValid,
  input  wire logic        resultReady
);

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0]             fsSync;
    logic [1:0]             sckSync;
    logic [1:0]             dinSync;
    logic [1:0]             cmpSync;
    logic                   fsPrev;
    logic                   sckPrev;
    logic [4:0]             cyc;
    sar_seq_pkg::phase_type phase;
    logic [7:0]             cmd;
    logic [1:0]             chanNext;
    logic [1:0]             chanCur;
    logic [7:0]             trial;
    logic [3:0]             bitIdx;
    logic [7:0]             headData;
    logic [1:0]             headChan;
    logic                   valid;
    logic                   dout;
    logic                   doutEn;
    logic [3:0]             sw;
    logic                   balance;
    logic [1:0][7:0]        bufData;
    logic [1:0][1:0]        bufChan;
    logic                   wrPtr;
    logic                   rdPtr;
    logic [1:0]             count;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic fsLow;
  logic sckRise;
  logic sckFall;
  logic frameStart;
  logic pushWord;
  logic popWord;
  logic bufFull;

  function automatic logic [3:0] chanOneHot(input logic [1:0] c);
    chanOneHot = 4'h1 << c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    // pins pass two flops before anything reads them
    s_d.fsSync  = {s_q.fsSync[0], frameSelectN};
    s_d.sckSync = {s_q.sckSync[0], serialClk};
    s_d.dinSync = {s_q.dinSync[0], cmdIn};
    s_d.cmpSync = {s_q.cmpSync[0], comparatorHigh};
    s_d.fsPrev  = s_q.fsSync[1];
    s_d.sckPrev = s_q.sckSync[1];
    fsLow       = ~s_q.fsSync[1];
    frameStart  = s_q.fsPrev & ~s_q.fsSync[1];
    sckRise     = fsLow & s_q.sckSync[1] & ~s_q.sckPrev;
    sckFall     = fsLow & ~s_q.sckSync[1] & s_q.sckPrev;
    bufFull     = (s_q.count == 2'h2);
    pushWord    = 1'b0;
    popWord     = s_q.valid & resultReady;
    s_d.doutEn  = fsLow;
    if (frameStart) begin
      // clock parked low: the select fall itself counts as the first falling edge
      s_d.cyc     = 5'h01;
      s_d.phase   = sar_seq_pkg::TRACK;
      s_d.cmd     = 8'h00;
      s_d.chanCur = s_q.chanNext;
      s_d.dout    = 1'b0;
    end else if (!fsLow) begin
      s_d.phase = sar_seq_pkg::IDLE;
      s_d.cyc   = 5'h00;
    end else begin
      if (sckRise && s_q.cyc <= sar_seq_pkg::LAST_CMD_RISE) begin
        s_d.cmd = {s_q.cmd[6:0], s_q.dinSync[1]};
        if (s_q.cyc == sar_seq_pkg::LAST_CMD_RISE) begin
          // only bits 4 and 3 matter, next conversion's channel
          s_d.chanNext = {s_q.cmd[sar_seq_pkg::CHAN_HI_POS - 1],
                          s_q.cmd[sar_seq_pkg::CHAN_LO_POS - 1]};
        end
      end
      if (sckRise && s_q.phase == sar_seq_pkg::HOLD) begin
        // one trial per rising edge; comparator low keeps the bit
        if (s_q.bitIdx < 4'h8) begin
          s_d.trial[3'(7 - s_q.bitIdx)] = ~s_q.cmpSync[1];
          if (s_q.bitIdx < 4'h7)
            s_d.trial[3'(6 - s_q.bitIdx)] = 1'b1;
          s_d.bitIdx = s_q.bitIdx + 4'h1;
        end
      end
      if (sckFall) begin
        if (s_q.cyc == sar_seq_pkg::GROUP_END) begin
          // next group reuses the address caught in this one
          s_d.cyc     = 5'h01;
          s_d.phase   = sar_seq_pkg::TRACK;
          s_d.chanCur = s_q.chanNext;
          s_d.cmd     = 8'h00;
          if (!bufFull) begin
            pushWord = 1'b1;
          end
        end else begin
          s_d.cyc = s_q.cyc + 5'h01;
        end
        if (s_q.cyc + 5'h01 == sar_seq_pkg::HOLD_EDGE) begin
          s_d.phase  = sar_seq_pkg::HOLD;
          s_d.trial  = 8'h80;
          s_d.bitIdx = 4'h0;
        end
        if (s_q.cyc + 5'h01 >= sar_seq_pkg::FIRST_OUT_CLK && s_q.cyc != sar_seq_pkg::GROUP_END)
          // result bits trail the SAR by one clock, msb first
          s_d.dout = s_q.trial[3'(8 - (s_q.cyc + 5'h01 - sar_seq_pkg::FIRST_OUT_CLK + 5'h01))];
      end
    end
    // sample switch follows the current channel only while tracking
    s_d.sw      = (s_d.phase == sar_seq_pkg::TRACK) ? chanOneHot(s_d.chanCur) : 4'h0;
    s_d.balance = (s_d.phase == sar_seq_pkg::TRACK);
    // two-entry buffer; a word finished while full is dropped rather than stalling the pins
    if (pushWord) begin
      s_d.bufData[s_q.wrPtr] = s_q.trial;
      s_d.bufChan[s_q.wrPtr] = s_q.chanCur;
      s_d.wrPtr              = ~s_q.wrPtr;
    end
    if (popWord)
      s_d.rdPtr = ~s_q.rdPtr;
    s_d.count = s_q.count + {1'b0, pushWord} - {1'b0, popWord};
    // buffer head kept in flops so the system side sees registered outputs
    s_d.valid    = (s_d.count != 2'h0);
    s_d.headData = s_d.bufData[s_d.rdPtr];
    s_d.headChan = s_d.bufChan[s_d.rdPtr];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q          <= '0;
      s_q.fsSync   <= 2'h3;
      s_q.fsPrev   <= 1'b1;
      s_q.phase    <= sar_seq_pkg::IDLE;
      s_q.chanNext <= sar_seq_pkg::CHAN_RESET;
      s_q.chanCur  <= sar_seq_pkg::CHAN_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign resultOut               = s_q.dout;
  assign resultOutEn             = s_q.doutEn;
  assign sampleSwitch            = s_q.sw;
  assign comparatorBalanceSwitch = s_q.balance;
  assign dacCode                 = s_q.trial;
  assign resultData              = s_q.headData;
  assign resultChannel           = s_q.headChan;
  assign resultValid             = s_q.valid;

  ////////////////////////////////////////////////////////////////////////////////
  a_release_when_high: assert property (@(posedge clk_sys) disable iff (rst)
    s_q.fsSync[1] |=> !resultOutEn) else $error("result pin driven while deselected");
  a_drive_when_low: assert property (@(posedge clk_sys) disable iff (rst)
    !s_q.fsSync[1] |=> resultOutEn) else $error("result pin idle while selected");
  a_frame_restart: assert property (@(posedge clk_sys) disable iff (rst)
    frameStart |=> s_q.cyc == 5'h01 && s_q.phase == sar_seq_pkg::TRACK) else $error("no restart");
  a_track_early: assert property (@(posedge clk_sys) disable iff (rst)
    (fsLow && s_q.cyc inside {[5'h01:5'h03]}) |-> s_q.phase == sar_seq_pkg::TRACK)
    else $error("not tracking in first cycles");
  a_hold_late: assert property (@(posedge clk_sys) disable iff (rst)
    (fsLow && !frameStart && s_q.cyc >= 5'h04) |-> s_q.phase == sar_seq_pkg::HOLD)
    else $error("not holding in cycles four to sixteen");
  a_hold_edge: assert property (@(posedge clk_sys) disable iff (rst)
    (sckFall && s_q.cyc == 5'h03) |=> s_q.phase == sar_seq_pkg::HOLD && dacCode == 8'h80)
    else $error("hold not at fourth fall");
  a_switch_open_hold: assert property (@(posedge clk_sys) disable iff (rst)
    s_q.phase == sar_seq_pkg::HOLD |-> sampleSwitch == 4'h0 && !comparatorBalanceSwitch)
    else $error("switch closed in hold");
  a_switch_channel: assert property (@(posedge clk_sys) disable iff (rst)
    s_q.phase == sar_seq_pkg::TRACK |-> sampleSwitch == chanOneHot(s_q.chanCur))
    else $error("wrong channel tracked");
  a_buffer_bound: assert property (@(posedge clk_sys) disable iff (rst)
    s_q.count <= 2'h2) else $error("buffer overflow");

endmodule // sar_adc_serial_frame_sequencer
`default_nettype wire

// ### tb/serial_host_model.sv
// host serial controller model: frame select, serial clock, command bits
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  // bench clock
  input  wire logic clk_sys,
  // serial pins
  output logic      frameSelectN,
  output logic      serialClk,
  output logic      cmdIn,
  input  wire logic resultOut
);
  logic [7:0] words[$];
  logic [7:0] sr;
  initial begin
    frameSelectN = 1'b1;
    serialClk    = 1'b0;
    cmdIn        = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // clock stands low outside frames, so select fall is the first falling edge
  task automatic run_frame(input int clocks, input logic [7:0] cmd);
    @(negedge clk_sys);
    #17 frameSelectN = 1'b0;
    for (int i = 0; i < clocks; i++) begin
      // read just before the pin moves: value of clock i, MSB first from clock five
      if (i % 16 >= 5 && i % 16 <= 12) sr = {sr[6:0], resultOut};
      if (i % 16 == 12) words.push_back(sr); // one word per group
      cmdIn = (i % 16 < 8) ? cmd[7 - i % 16] : ~cmdIn; // next address, first 8 bits
      #400 serialClk = 1'b1;
      #400 serialClk = 1'b0;
    end
    // whole groups only, except where a scenario cuts a frame short
    #400 frameSelectN = 1'b1;
    cmdIn = ~cmdIn;
  endtask
endmodule // serial_host_model
`default_nettype wire

// ### tb/sar_adc_serial_frame_sequencer_tb_top.sv
// testbench for the serial-frame conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module sar_adc_serial_frame_sequencer_tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, comparatorHigh = 1'b0, resultReady = 1'b0;
  logic frameSelectN, serialClk, cmdIn, resultOut, resultOutEn, comparatorBalanceSwitch;
  logic selD, stall = 1'b0, resultValid;
  logic [1:0] chanNow = 2'h0, chanNext = 2'h0, resultChannel;
  logic [3:0] sampleSwitch;
  logic [7:0] dacCode, resultData, anaVal[4];
  logic [9:0] expS[$], expB[$];
  int fails = 0, cmpCount = 0, cyc = 0, quiet = 0, seed = 32'h2C41;
  always #50 clk_sys = ~clk_sys;
  sar_adc_serial_frame_sequencer sar_adc_serial_frame_sequencer_inst (.clk_sys(clk_sys),
    .rst(rst), .frameSelectN(frameSelectN), .serialClk(serialClk), .cmdIn(cmdIn),
    .resultOut(resultOut), .resultOutEn(resultOutEn), .comparatorHigh(comparatorHigh),
    .sampleSwitch(sampleSwitch), .comparatorBalanceSwitch(comparatorBalanceSwitch),
    .dacCode(dacCode), .resultData(resultData), .resultChannel(resultChannel),
    .resultValid(resultValid), .resultReady(resultReady));
  serial_host_model serial_host_model_inst (.clk_sys(clk_sys), .frameSelectN(frameSelectN),
    .serialClk(serialClk), .cmdIn(cmdIn), .resultOut(resultOut));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compares=%0d mismatches=%0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic new_inputs;
    for (int c = 0; c < 4; c++) anaVal[c] = 8'($random(seed));
  endtask
  // expected words follow the address of the previous group
  task automatic frame(input int clocks, input logic [7:0] cmd);
    logic [9:0] e;
    for (int g = 0; g < clocks / 16; g++) begin
      expS.push_back({chanNext, anaVal[chanNext]});
      expB.push_back({chanNext, anaVal[chanNext]});
      chanNext = cmd[4:3];
    end
    serial_host_model_inst.run_frame(clocks, cmd);
    repeat (10) @(negedge clk_sys);
    while (serial_host_model_inst.words.size() > 0) begin
      e = expS.pop_front();
      check({2'h0, serial_host_model_inst.words.pop_front()}, {2'h0, e[7:0]});
    end
    check(10'(expS.size()), 10'h000);
  endtask
  task automatic drain(input int n);
    for (int w = 0; w < 2000 && expB.size() > 0; w++) @(negedge clk_sys);
    check(10'(expB.size()), 10'h000);
    $display("test %0d done", n);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // comparator: trial above the held input clears its bit
  always @(negedge clk_sys) begin
    for (int c = 0; c < 4; c++) if (sampleSwitch[c]) chanNow = c[1:0];
    comparatorHigh <= dacCode > anaVal[chanNow];
    resultReady <= !stall && ($random(seed) % 2 != 0);
    selD <= frameSelectN;
    quiet <= (selD != frameSelectN) ? 0 : quiet + 1;
    if (quiet == 6) check({9'h0, resultOutEn}, {9'h0, ~frameSelectN});
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (resultValid && resultReady && !rst)
      check({resultChannel, resultData}, expB.pop_front());
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    repeat (5) @(negedge clk_sys);
    anaVal = '{8'h00, 8'hFF, 8'h01, 8'h80};
    for (int c = 0; c < 4; c++) frame(16, {3'h5, c[1:0] + 2'h1, 3'h2});
    drain(1);
    new_inputs();
    frame(48, 8'($random(seed)));
    drain(2);
    // a cut-short frame yields no word and the next starts afresh
    frame(5, {3'h0, chanNext, 3'h0});
    frame(16, 8'($random(seed)));
    drain(3);
    // two-entry buffer holds two words, the third is lost
    stall = 1'b1;
    frame(48, 8'($random(seed)));
    void'(expB.pop_back());
    repeat (20) @(negedge clk_sys);
    stall = 1'b0;
    drain(4);
    repeat (6) begin
      new_inputs();
      frame(16 + 16 * ($random(seed) & 1), 8'($random(seed)));
    end
    drain(5);
    close_out();
  end
endmodule // sar_adc_serial_frame_sequencer_tb_top
`default_nettype wire
